/* File: rtl/sem_host_pkg.sv */
// Purpose: types for the semaphore port controller
// Assumes: constants come from sem_host_regs.svh
// Notes: none
package sem_host_pkg;

   // ****************************************************
   // commands, states and pin bundles
   // ****************************************************
   typedef enum logic [1:0] {
      OP_CLAIM   = 2'h0,
      OP_RELEASE = 2'h1,
      OP_POLL    = 2'h2,
      OP_INIT    = 2'h3
   } sem_op_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_LOOK    = 3'h1,
      ST_SETUP   = 3'h3,
      ST_WSTROBE = 3'h2,
      ST_WHOLD   = 3'h6,
      ST_GAP     = 3'h7,
      ST_READ    = 3'h5,
      ST_DONE    = 3'h4
   } ctrl_state_t;

   typedef struct packed {
      sem_op_t    op;
      logic [2:0] index;
   } sem_cmd_t;

   typedef struct packed {
      logic granted;
      logic error;
   } sem_rsp_t;

   typedef struct packed {
      logic        ce_n;
      logic        semaphore_select_n;
      logic        oe_n;
      logic        rw_n;
      logic        ub_n;
      logic        lb_n;
      logic [2:0]  index_lines;
      logic [15:0] data_o;
      logic        data_oe_n;
   } sem_pins_t;

endpackage

/* File: rtl/sem_host_regs.svh */
// Purpose: constants for the semaphore port controller
// Assumes: 20 MHz reference clock
// Notes: timing counts derive from times in ns
//
// Overview of operation
// - Controller holds address and select stable before asserting its write strobe.
// - System uses just one master per width-expanded array.
// - Polling controller drops select or output enable between reads.
// - Claim means write zero then read back; zero read means owned.
// - Flags start unknown; init writes one to all eight from each port.
`ifndef SEM_HOST_REGS_SVH
`define SEM_HOST_REGS_SVH

// ****************************************************
// sizes and fields
// ****************************************************
`define SEM_COUNT        8
`define SEM_IDX_W        3
`define SEM_DATA_W       16
`define SEM_FLAG_BIT     0
`define SEM_LAST_IDX     3'h7

// ****************************************************
// timing
// ****************************************************
`define REF_CLK_MHZ      20
`define SEM_SETUP_NS     20
`define SEM_WP_NS        30
`define SEM_HOLD_NS      10
`define SEM_GAP_NS       20
`define SEM_RD_NS        40
`define NS_TO_CYC(ns)    (((ns) * `REF_CLK_MHZ + 999) / 1000)
`define SEM_SETUP_CYC    `NS_TO_CYC(`SEM_SETUP_NS)
`define SEM_WP_CYC       `NS_TO_CYC(`SEM_WP_NS)
`define SEM_HOLD_CYC     `NS_TO_CYC(`SEM_HOLD_NS)
`define SEM_GAP_CYC      `NS_TO_CYC(`SEM_GAP_NS)
`define SEM_RD_CYC       `NS_TO_CYC(`SEM_RD_NS)

`endif

/* File: rtl/sem_port_ctrl.sv */
// Purpose: drives one port's semaphore pins of a dual-port RAM
// Assumes: data pins sampled synchronously to ref_clk
// Notes: memory array accesses are not issued; chip select stays high
`timescale 1ns/10ps
`include "sem_host_regs.svh"
module sem_port_ctrl
   import sem_host_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   rstn,
   input  wire logic                   cmd_valid,
   input  wire sem_cmd_t               cmd,
   output logic                        cmd_ready,
   output logic                        rsp_valid,
   output sem_rsp_t                    rsp,
   output sem_pins_t                   pins,
   input  wire logic [`SEM_DATA_W-1:0] data_i
);
   ctrl_state_t             state_reg;
   ctrl_state_t             state_next;
   logic [3:0]              cnt_reg;
   logic [3:0]              cnt_next;
   sem_op_t                 op_reg;
   logic [`SEM_IDX_W-1:0]   idx_reg;
   logic [`SEM_IDX_W-1:0]   idx_next;
   logic                    held_rd;
   logic                    tbl_wr;
   logic                    tbl_bit;
   logic                    rd_all_zero;
   logic                    rd_all_one;

   // ****************************************************
   // helpers
   // ****************************************************
   // operations that write the request latch
   function automatic logic is_write_op(input sem_op_t op);
      is_write_op = (op != OP_POLL);
   endfunction

   // pin levels for a given state
   function automatic sem_pins_t pins_for(input ctrl_state_t st,
                                          input sem_op_t op,
                                          input logic [`SEM_IDX_W-1:0] idx);
      sem_pins_t p;
      p                    = '0;
      p.ce_n               = 1'b1;
      p.ub_n               = 1'b1;
      p.lb_n               = 1'b1;
      p.rw_n               = 1'b1;
      p.oe_n               = 1'b1;
      p.data_oe_n          = 1'b1;
      p.semaphore_select_n = 1'b1;
      p.index_lines        = idx;
      p.data_o[`SEM_FLAG_BIT] = (op != OP_CLAIM);
      unique case (st)
         ST_SETUP, ST_WHOLD: begin
            p.semaphore_select_n = 1'b0;
            p.data_oe_n          = !is_write_op(op);
         end
         ST_WSTROBE: begin
            p.semaphore_select_n = 1'b0;
            p.rw_n               = 1'b0;
            p.data_oe_n          = 1'b0;
         end
         ST_READ: begin
            p.semaphore_select_n = 1'b0;
            p.oe_n               = 1'b0;
         end
         ST_IDLE, ST_LOOK, ST_GAP, ST_DONE: begin
            p.semaphore_select_n = 1'b1;
         end
      endcase
      return p;
   endfunction

   // ****************************************************
   // held-token memory
   // ****************************************************
   // read with the coming index so the lookup state sees the token just taken
   token_table i_token_table (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .wr_en   (tbl_wr),
      .wr_idx  (idx_reg),
      .wr_bit  (tbl_bit),
      .rd_idx  (idx_next),
      .rd_data (held_rd)
   );

   // ****************************************************
   // sequencing
   // ****************************************************
   assign rd_all_zero = (data_i == '0);
   assign rd_all_one  = (data_i == '1);

   // next state and counter
   always_comb begin
      state_next = state_reg;
      cnt_next   = (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
      idx_next   = idx_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (cmd_valid && cmd_ready) begin
               state_next = ST_LOOK;
               idx_next   = (cmd.op == OP_INIT) ? '0 : cmd.index;
            end
         end
         ST_LOOK: begin
            if (op_reg == OP_CLAIM && held_rd) begin
               state_next = ST_DONE;
            end else begin
               state_next = ST_SETUP;
               cnt_next   = 4'(`SEM_SETUP_CYC - 1);
            end
         end
         ST_SETUP: begin
            if (cnt_reg == 4'h0) begin
               if (is_write_op(op_reg)) begin
                  state_next = ST_WSTROBE;
                  cnt_next   = 4'(`SEM_WP_CYC - 1);
               end else begin
                  state_next = ST_READ;
                  cnt_next   = 4'(`SEM_RD_CYC - 1);
               end
            end
         end
         ST_WSTROBE: begin
            if (cnt_reg == 4'h0) begin
               state_next = ST_WHOLD;
               cnt_next   = 4'(`SEM_HOLD_CYC - 1);
            end
         end
         ST_WHOLD: begin
            if (cnt_reg == 4'h0) begin
               state_next = ST_GAP;
               cnt_next   = 4'(`SEM_GAP_CYC - 1);
            end
         end
         ST_GAP: begin
            if (cnt_reg == 4'h0) begin
               if (op_reg == OP_CLAIM) begin
                  state_next = ST_READ;
                  cnt_next   = 4'(`SEM_RD_CYC - 1);
               end else if (op_reg == OP_INIT && idx_reg != `SEM_LAST_IDX) begin
                  state_next = ST_SETUP;
                  idx_next   = idx_reg + 3'h1;
                  cnt_next   = 4'(`SEM_SETUP_CYC - 1);
               end else begin
                  state_next = ST_DONE;
               end
            end
         end
         ST_READ: begin
            if (cnt_reg == 4'h0) begin
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // state, counter, command capture
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 4'h0;
         idx_reg   <= '0;
         op_reg    <= OP_POLL;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         idx_reg   <= idx_next;
         if (state_reg == ST_IDLE && cmd_valid && cmd_ready) begin
            op_reg <= cmd.op;
         end
      end
   end

   // ****************************************************
   // token bookkeeping
   // ****************************************************
   // record ownership after reads, drop it on release or init
   always_comb begin
      tbl_wr  = 1'b0;
      tbl_bit = 1'b0;
      if (state_reg == ST_READ && cnt_reg == 4'h0) begin
         tbl_wr  = 1'b1;
         tbl_bit = rd_all_zero;
      end else if (state_reg == ST_WSTROBE && op_reg != OP_CLAIM) begin
         tbl_wr  = 1'b1;
         tbl_bit = 1'b0;
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************
   // pins registered from the coming state
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pins <= pins_for(ST_IDLE, OP_POLL, '0);
      end else begin
         pins <= pins_for(state_next, op_reg, idx_next);
      end
   end

   // command handshake
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cmd_ready <= 1'b0;
      end else begin
         cmd_ready <= (state_next == ST_IDLE) && !(cmd_valid && cmd_ready);
      end
   end

   // answer pulse; a failed claim leaves the request latch at zero
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rsp_valid <= 1'b0;
         rsp       <= '0;
      end else begin
         rsp_valid <= (state_next == ST_DONE);
         if (state_reg == ST_LOOK && state_next == ST_DONE) begin
            rsp <= '{granted: 1'b1, error: 1'b0};
         end else if (state_reg == ST_READ && cnt_reg == 4'h0) begin
            rsp <= '{granted: rd_all_zero,
                     error: !(rd_all_zero || rd_all_one)};
         end else if (state_reg == ST_GAP && state_next == ST_DONE) begin
            rsp <= '0;
         end
      end
   end
endmodule // sem_port_ctrl

/* File: rtl/token_table.sv */
// Purpose: remembers which semaphores this port holds
// Assumes: one write and one read port, read data registered
// Notes: contents cleared by reset
`timescale 1ns/10ps
`include "sem_host_regs.svh"
module token_table (
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   input  wire logic                  wr_en,
   input  wire logic [`SEM_IDX_W-1:0] wr_idx,
   input  wire logic                  wr_bit,
   input  wire logic [`SEM_IDX_W-1:0] rd_idx,
   output logic                       rd_data
);
   logic [`SEM_COUNT-1:0] held_reg;

   // ****************************************************
   // storage and registered read
   // ****************************************************
   // one bit per token
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         held_reg <= '0;
      end else if (wr_en) begin
         held_reg[wr_idx] <= wr_bit;
      end
   end

   // read data from a flop
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rd_data <= 1'b0;
      end else begin
         rd_data <= held_reg[rd_idx];
      end
   end
endmodule // token_table

/* File: verif/sem_dev_model.sv */
// Purpose: behavioural eight-token semaphore device, two ports
// Assumes: left port is the controller pins, right port a simple strobe
// Notes: garble flips data bit 5 on reads for error tests
`timescale 1ns/10ps
module sem_dev_model
   import sem_host_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire sem_pins_t   pins,
   output logic [15:0]      data_i,
   input  wire logic        r_wr,
   input  wire logic [2:0]  r_idx,
   input  wire logic        r_bit,
   input  wire logic        garble,
   input  wire logic        master_sel,
   input  wire logic        r_ce_n,
   output logic [7:0]       r_flag,
   output logic             conflict_l,
   output logic             conflict_r
);
   // ************************************************
   // token latches
   // ************************************************
   logic [1:0]  own [8] = '{default: 2'h1}; // 0 free, 1 left, 2 right
   logic [7:0]  req_l = 8'h00;              // not cleared at power-up
   logic [7:0]  req_r = 8'h00;
   logic [7:0]  l_flag;
   logic        rd_open = 1'b0;
   logic [15:0] rd_val = 16'h0000;
   logic [15:0] last = 16'h0000;
   logic        lw;
   logic        rd;
   assign lw = !pins.semaphore_select_n && !pins.rw_n && !pins.data_oe_n;
   assign rd = !pins.semaphore_select_n && !pins.oe_n;
   // master conflict flags from master select, memory selects and index; left wins, never both low
   assign conflict_l = 1'b1;
   assign conflict_r = !(master_sel && !pins.ce_n && !r_ce_n
                         && pins.index_lines == r_idx);
   // each side reads zero only while it owns
   always_comb for (int i = 0; i < 8; i++) begin
      l_flag[i] = own[i] != 2'h1;
      r_flag[i] = own[i] != 2'h2;
   end
   // request latches and ownership hand-over
   always @(posedge ref_clk) begin : latches
      logic [7:0] ql;
      logic [7:0] qr;
      logic [1:0] o;
      ql = req_l;
      qr = req_r;
      if (lw) ql[pins.index_lines] = pins.data_o[0];
      if (r_wr) qr[r_idx] = r_bit;
      for (int i = 0; i < 8; i++) begin
         o = own[i];
         if ((o == 2'h1 && ql[i]) || (o == 2'h2 && qr[i])) o = 2'h0;
         if (o == 2'h0) o = !ql[i] ? 2'h1 : (!qr[i] ? 2'h2 : 2'h0);
         own[i] <= o;
      end
      req_l <= ql;
      req_r <= qr;
   end
   // read value frozen while select and enable stay low
   always @(posedge ref_clk) begin
      rd_open <= rd;
      if (rd && !rd_open) rd_val <= {16{l_flag[pins.index_lines]}};
      if (rd) last <= data_i;
   end
   assign data_i = rd ? ((rd_open ? rd_val : {16{l_flag[pins.index_lines]}})
                   ^ {10'h000, garble, 5'h00}) : ~last;
endmodule // sem_dev_model

/* File: verif/sem_port_ctrl_monitor.sv */
// Purpose: pin and handshake checks for sem_port_ctrl
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every sem_port_ctrl instance
`timescale 1ns/10ps
`include "sem_host_regs.svh"
module sem_port_ctrl_monitor
   import sem_host_pkg::*;
(
   input wire logic                   ref_clk,
   input wire logic                   rstn,
   input wire logic                   cmd_valid,
   input wire sem_cmd_t               cmd,
   input wire logic                   cmd_ready,
   input wire logic                   rsp_valid,
   input wire sem_rsp_t               rsp,
   input wire sem_pins_t              pins,
   input wire logic [`SEM_DATA_W-1:0] data_i
);
   // ************************************************
   // properties
   // ************************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   a_reset_idle: assert property ($rose(rstn) |-> pins.semaphore_select_n && pins.oe_n
      && pins.rw_n && !cmd_ready)
      else $error("outputs not idle after reset");
   a_standby_pins: assert property (pins.ce_n && pins.ub_n && pins.lb_n)
      else $error("memory select or byte select driven");
   a_strobe_qual: assert property (!pins.rw_n |-> !pins.semaphore_select_n
      && !pins.data_oe_n && pins.oe_n)
      else $error("write strobe without semaphore cycle");
   a_strobe_setup: assert property ($fell(pins.rw_n) |-> $past(!pins.semaphore_select_n)
      && $stable(pins.index_lines) && $stable(pins.data_o))
      else $error("index or data not set up before strobe");
   a_strobe_hold: assert property ($rose(pins.rw_n) |-> !pins.semaphore_select_n
      && !pins.data_oe_n && $stable(pins.index_lines))
      else $error("select or index dropped with strobe");
   a_data_bit: assert property (!pins.data_oe_n |-> pins.data_o[15:1] == 15'h0000)
      else $error("upper data bits driven");
   a_read_drop: assert property (!pins.oe_n |-> !pins.semaphore_select_n && pins.rw_n
      ##1 pins.oe_n)
      else $error("read not released after one cycle");
   a_grant_data: assert property (!pins.oe_n |=> rsp_valid
      && rsp.granted == ($past(data_i) == 16'h0000)
      && rsp.error == ($past(data_i) != 16'h0000 && $past(data_i) != 16'hFFFF))
      else $error("answer does not match read data");
   a_release_time: assert property (cmd_valid && cmd_ready && cmd.op == OP_RELEASE
      |-> ##6 rsp_valid && !rsp.granted)
      else $error("release answer late or granted");
   a_claim_time: assert property (cmd_valid && cmd_ready && cmd.op == OP_CLAIM
      |-> ##[2:7] rsp_valid)
      else $error("claim answer missing");
   a_ready_back: assert property (rsp_valid |=> cmd_ready && !rsp_valid)
      else $error("ready not back after answer");
endmodule // sem_port_ctrl_monitor
bind sem_port_ctrl sem_port_ctrl_monitor i_mon (.ref_clk(ref_clk), .rstn(rstn),
   .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
   .pins(pins), .data_i(data_i));

/* File: verif/tb_sem_port_ctrl.sv */
// Purpose: self-checking bench for sem_port_ctrl
// Assumes: sem_dev_model stands on the pins
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/10ps
module tb_sem_port_ctrl;
   import sem_host_pkg::*;
   // ************************************************
   // stimulus and harness
   // ************************************************
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        cmd_valid = 1'b0;
   sem_cmd_t    cmd = '0;
   logic        cmd_ready, rsp_valid, r_wr = 1'b0, r_bit = 1'b1, garble = 1'b0;
   sem_rsp_t    rsp, got;
   sem_pins_t   pins;
   logic [15:0] data_i;
   logic [2:0]  r_idx = 3'h0;
   logic [7:0]  r_flag;
   logic        master_sel = 1'b1;
   logic        r_ce_n = 1'b1;
   logic        conflict_l;
   logic        conflict_r;
   int          miscompares = 0;
   int          checks = 0;
   always #25 ref_clk = ~ref_clk;
   sem_port_ctrl i_sem_port_ctrl (.ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .data_i(data_i));
   sem_dev_model i_sem_dev_model (.ref_clk(ref_clk), .pins(pins), .data_i(data_i), .r_wr(r_wr),
      .r_idx(r_idx), .r_bit(r_bit), .garble(garble), .master_sel(master_sel),
      .r_ce_n(r_ce_n), .r_flag(r_flag), .conflict_l(conflict_l), .conflict_r(conflict_r));
   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one command through the handshake, answer left in got
   task automatic run(input sem_op_t op, input logic [2:0] idx);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         tick;
         n++;
      end
      if (n >= 100) begin
         miscompares++;
         give_verdict;
      end
      cmd = '{op: op, index: idx};
      cmd_valid = 1'b1;
      tick;
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 200) begin
         tick;
         n++;
      end
      if (n >= 200) begin
         miscompares++;
         give_verdict;
      end
      got = rsp;
   endtask
   // right-side processor writes one flag bit
   task automatic rwr(input logic [2:0] idx, input logic b);
      r_idx = idx;
      r_bit = b;
      r_wr = 1'b1;
      tick;
      r_wr = 1'b0;
      tick;
   endtask
   task automatic t_init;
      run(OP_INIT, 3'h0);
      check(r_flag, 8'h00);
      check({conflict_l, conflict_r}, 2'h3);
      for (int i = 0; i < 8; i++) rwr(i[2:0], 1'b1);
      check(r_flag, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         run(OP_POLL, i[2:0]);
         check(got.granted, 1'b0);
      end
      $display("test init done");
   endtask
   task automatic t_contend;
      run(OP_CLAIM, 3'h3);
      check(got.granted, 1'b1);
      check(r_flag, 8'hFF);
      run(OP_CLAIM, 3'h3);
      check(got.granted, 1'b1);
      rwr(3'h3, 1'b0);
      run(OP_POLL, 3'h3);
      check(got.granted, 1'b1);
      run(OP_RELEASE, 3'h3);
      run(OP_POLL, 3'h3);
      check(got.granted, 1'b0);
      run(OP_CLAIM, 3'h3);
      check(got.granted, 1'b0);
      rwr(3'h3, 1'b1);
      check(r_flag, 8'hFF);
      run(OP_POLL, 3'h3);
      check(got.granted, 1'b1);
      run(OP_RELEASE, 3'h3);
      rwr(3'h3, 1'b0);
      check(r_flag, 8'hF7);
      rwr(3'h3, 1'b1);
      $display("test contend done");
   endtask
   task automatic t_index;
      for (int i = 0; i < 8; i += 2) begin
         run(OP_CLAIM, i[2:0]);
         check(got.granted, 1'b1);
      end
      for (int i = 0; i < 8; i++) begin
         run(OP_POLL, i[2:0]);
         check(got.granted, !i[0]);
      end
      check(r_flag, 8'hFF);
      for (int i = 0; i < 8; i += 2) run(OP_RELEASE, i[2:0]);
      for (int i = 0; i < 8; i++) rwr(i[2:0], 1'b0);
      check(r_flag, 8'h00);
      $display("test index done");
   endtask
   task automatic t_error;
      garble = 1'b1;
      run(OP_POLL, 3'h5);
      check(got.error, 1'b1);
      garble = 1'b0;
      run(OP_POLL, 3'h5);
      check({got.error, got.granted}, 2'h0);
      $display("test error done");
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      #1 rstn = 1'b1;
      t_init;
      t_contend;
      t_index;
      t_error;
      give_verdict;
   end
endmodule // tb_sem_port_ctrl
